// File: rtl/tpfs_pkg.sv
// package of pin-function codes and field layouts for the timer pin select block
package tpfs_pkg;

  // timer b operating mode field values (hi,lo)
  localparam logic [1:0] TPFS_TB_WAVE      = 2'h1;
  localparam logic [1:0] TPFS_TB_ONESHOT   = 2'h2;
  localparam logic [1:0] TPFS_TB_WAITSHOT  = 2'h3;

  // timer c channel io field bit positions
  localparam int TPFS_IO_TOP_BIT  = 2;
  localparam int TPFS_IO_LOW_HI   = 1;
  localparam int TPFS_IO_LOW_LO   = 0;

  // trigger edge field: 00 means no trigger input
  localparam logic [1:0] TPFS_EDGE_NONE = 2'h0;

  // reset values of the registered outputs
  localparam logic       TPFS_RST_BIT   = 1'h0;
  localparam logic [2:0] TPFS_RST_FUNC  = 3'h0;

  // timer b pin role, one-hot
  typedef enum logic [4:0] {
    TPFS_TB_IDLE  = 5'h01,
    TPFS_TB_PULSE = 5'h02,
    TPFS_TB_PROG  = 5'h04,
    TPFS_TB_SHOT  = 5'h08,
    TPFS_TB_WSHOT = 5'h10
  } tpfs_tb_role_t;

  // timer c channel pin role code
  typedef enum logic [2:0] {
    TPFS_CH_NONE = 3'h0,
    TPFS_CH_OC   = 3'h1,
    TPFS_CH_IC   = 3'h2,
    TPFS_CH_PWM  = 3'h3,
    TPFS_CH_PWM_TWO = 3'h4,
    TPFS_CH_TRIG = 3'h5
  } tpfs_ch_role_t;

  // per-channel control bits
  typedef struct packed {
    logic       out_off;   // channel output-disable bit
    logic       pwm_sel;   // channel pwm select (unused on channel a)
    logic [2:0] io_ctl;    // channel io field, top bit selects capture
  } tpfs_chan_ctl_t;

  // port 4 control bits
  typedef struct packed {
    logic port45_direction;
    logic ext_irq0_pin_enable;
    logic port4_group_pullup;
    logic all_clock_stop;
    logic sub_osc_buf_req;
    logic sub_osc_fb_req;
  } tpfs_port4_ctl_t;

endpackage : tpfs_pkg

// File: rtl/tpfs_chan_dec.sv
// decoder of one timer c channel pin role
`timescale 1ns/10ps
module tpfs_chan_dec
  import tpfs_pkg::*;
#(
  parameter bit IS_CHAN_A = 1'b0,  // channel a has no pwm modes of its own
  parameter bit IS_CHAN_B = 1'b0   // only channel b carries the pwm-two waveform
) (
  input  wire tpfs_chan_ctl_t ctl_i,         // channel control bits
  input  wire logic           pwm_two_sel_i, // pwm-two select (0 = pwm-two mode)
  input  wire logic [1:0]     trig_edge_i,   // trigger edge field (hi,lo)
  output tpfs_ch_role_t       role_o         // decoded pin role
);

  // elaboration check: one decoder cannot serve both channel a and channel b
  if (IS_CHAN_A && IS_CHAN_B) begin : g_bad_chan
    $error("tpfs_chan_dec: a channel cannot be both a and b");
  end

  // pin role from current control bits
  always_comb begin
    role_o = TPFS_CH_NONE;
    if (pwm_two_sel_i && (IS_CHAN_A || !ctl_i.pwm_sel)) begin
      if (ctl_i.io_ctl[TPFS_IO_TOP_BIT]) begin
        role_o = TPFS_CH_IC;
      end else if (!ctl_i.out_off &&
                   (ctl_i.io_ctl[TPFS_IO_LOW_HI] || ctl_i.io_ctl[TPFS_IO_LOW_LO])) begin
        role_o = TPFS_CH_OC;
      end
    end else if (pwm_two_sel_i && !IS_CHAN_A && !ctl_i.out_off) begin
      role_o = TPFS_CH_PWM;
    end else if (!pwm_two_sel_i && IS_CHAN_B && !ctl_i.out_off && !ctl_i.pwm_sel) begin
      role_o = TPFS_CH_PWM_TWO;
    end else if (!pwm_two_sel_i && IS_CHAN_A && ctl_i.out_off &&
                 (trig_edge_i != TPFS_EDGE_NONE)) begin
      role_o = TPFS_CH_TRIG;
    end
  end

endmodule // tpfs_chan_dec

// File: rtl/tpfs_top.sv
// timer and port 4 pin function select, registered outputs
`timescale 1ns/10ps
module tpfs_top
  import tpfs_pkg::*;
(
  input  wire logic            clock_i,             // 125 MHz system clock
  input  wire logic            rst_i,               // async reset, active high
  input  wire tpfs_port4_ctl_t port4_ctl_i,         // port 4 control bits
  input  wire logic            timer_b_output_ctl_i,// timer b output-control bit
  input  wire logic            timer_b_op_sel_hi_i, // timer b mode field high bit
  input  wire logic            timer_b_op_sel_lo_i, // timer b mode field low bit
  input  wire tpfs_chan_ctl_t  chan_a_ctl_i,        // timer c channel a controls
  input  wire tpfs_chan_ctl_t  chan_b_ctl_i,        // timer c channel b controls
  input  wire tpfs_chan_ctl_t  chan_c_ctl_i,        // timer c channel c controls
  input  wire tpfs_chan_ctl_t  chan_d_ctl_i,        // timer c channel d controls
  input  wire logic            pwm_two_sel_i,       // pwm-two select
  input  wire logic            trig_edge_sel_hi_i,  // trigger edge field high
  input  wire logic            trig_edge_sel_lo_i,  // trigger edge field low
  input  wire logic            port45_pad_i,        // port 4_5 pad level (async)
  input  wire logic            port45_out_i,        // port 4_5 output data
  input  wire logic            timer_c_pin_a_pad_i, // timer c pin a pad level (async)
  output logic                 port45_oe_o,         // port 4_5 drive enable
  output logic                 port45_o,            // port 4_5 drive level
  output logic                 port45_pullup_o,     // port 4_5 pull-up enable
  output logic                 port44_pullup_o,     // port 4_4 pull-up enable
  output logic                 ext_irq0_input_o,    // level fed to external irq 0
  output logic                 sub_osc_buf_en_o,    // sub-clock oscillation buffer on
  output logic                 sub_osc_fb_en_o,     // sub-clock feedback resistor on
  output tpfs_tb_role_t        timer_b_role_o,      // timer b pin role
  output logic                 timer_b_out_oe_o,    // timer b pin drive enable
  output logic [2:0]           chan_a_role_o,       // timer c pin a role code
  output logic [2:0]           chan_b_role_o,       // timer c pin b role code
  output logic [2:0]           chan_c_role_o,       // timer c pin c role code
  output logic [2:0]           chan_d_role_o,       // timer c pin d role code
  output logic                 timer_c_trig_in_o    // trigger level to timer c
);

  ////////////////////////////////////////////////////////////////////////////////
  // pad synchronisers
  logic [1:0] p45_sync_reg;   // port 4_5 pad, stage 0 then 1
  logic [1:0] p45_sync_next;
  logic [1:0] trg_sync_reg;   // pin a pad, stage 0 then 1
  logic [1:0] trg_sync_next;

  // shift pads into two-stage chains
  always_comb begin
    p45_sync_next = {p45_sync_reg[0], port45_pad_i};
    trg_sync_next = {trg_sync_reg[0], timer_c_pin_a_pad_i};
  end

  // register synchroniser stages
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      p45_sync_reg <= {2{TPFS_RST_BIT}};
      trg_sync_reg <= {2{TPFS_RST_BIT}};
    end else begin
      p45_sync_reg <= p45_sync_next;
      trg_sync_reg <= trg_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timer c channel decoders, combinational from the bits
  tpfs_ch_role_t role_a;  // channel a role
  tpfs_ch_role_t role_b;  // channel b role
  tpfs_ch_role_t role_c;  // channel c role
  tpfs_ch_role_t role_d;  // channel d role
  logic [1:0]    trig_edge;  // trigger edge field

  assign trig_edge = {trig_edge_sel_hi_i, trig_edge_sel_lo_i};

  tpfs_chan_dec #(.IS_CHAN_A(1'b1), .IS_CHAN_B(1'b0)) u_dec_a (
    .ctl_i         (chan_a_ctl_i),
    .pwm_two_sel_i (pwm_two_sel_i),
    .trig_edge_i   (trig_edge),
    .role_o        (role_a)
  );
  tpfs_chan_dec #(.IS_CHAN_A(1'b0), .IS_CHAN_B(1'b1)) u_dec_b (
    .ctl_i         (chan_b_ctl_i),
    .pwm_two_sel_i (pwm_two_sel_i),
    .trig_edge_i   (trig_edge),
    .role_o        (role_b)
  );
  tpfs_chan_dec #(.IS_CHAN_A(1'b0), .IS_CHAN_B(1'b0)) u_dec_c (
    .ctl_i         (chan_c_ctl_i),
    .pwm_two_sel_i (pwm_two_sel_i),
    .trig_edge_i   (trig_edge),
    .role_o        (role_c)
  );
  tpfs_chan_dec #(.IS_CHAN_A(1'b0), .IS_CHAN_B(1'b0)) u_dec_d (
    .ctl_i         (chan_d_ctl_i),
    .pwm_two_sel_i (pwm_two_sel_i),
    .trig_edge_i   (trig_edge),
    .role_o        (role_d)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next values of all pin outputs except the timer c channel roles
  logic          p45_oe_next;
  logic          p45_out_next;
  logic          p45_pu_next;
  logic          p44_pu_next;
  logic          irq0_next;
  logic          buf_next;
  logic          fb_next;
  tpfs_tb_role_t tb_role_next;
  logic          tb_oe_next;
  logic          trig_next;
  logic [1:0]    tb_mode;

  // decode port 4, sub-oscillator and timer b functions
  always_comb begin
    tb_mode      = {timer_b_op_sel_hi_i, timer_b_op_sel_lo_i};
    p45_oe_next  = port4_ctl_i.port45_direction;
    p45_out_next = port45_out_i;
    irq0_next    = !port4_ctl_i.port45_direction &&
                   port4_ctl_i.ext_irq0_pin_enable && p45_sync_reg[1];
    // pull-up only for an input pin with the group bit set
    p45_pu_next  = port4_ctl_i.port4_group_pullup &&
                   !port4_ctl_i.port45_direction;
    p44_pu_next  = port4_ctl_i.port4_group_pullup &&
                   !port4_ctl_i.sub_osc_buf_req;
    // stop mode overrides both sub-oscillator requests
    buf_next     = port4_ctl_i.sub_osc_buf_req && !port4_ctl_i.all_clock_stop;
    fb_next      = port4_ctl_i.sub_osc_fb_req && !port4_ctl_i.all_clock_stop;
    tb_role_next = TPFS_TB_IDLE;
    unique case (tb_mode)
      TPFS_TB_WAVE: begin
        tb_role_next = timer_b_output_ctl_i ? TPFS_TB_PROG : TPFS_TB_PULSE;
      end
      TPFS_TB_ONESHOT: begin
        if (!timer_b_output_ctl_i) tb_role_next = TPFS_TB_SHOT;
      end
      TPFS_TB_WAITSHOT: begin
        if (!timer_b_output_ctl_i) tb_role_next = TPFS_TB_WSHOT;
      end
      default: begin
        tb_role_next = TPFS_TB_IDLE;  // timer mode, no pin role
      end
    endcase
    tb_oe_next   = (tb_role_next != TPFS_TB_IDLE);
    trig_next    = (role_a == TPFS_CH_TRIG) && trg_sync_reg[1];
  end

  // register outputs, one cycle after the bits change
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      port45_oe_o       <= TPFS_RST_BIT;
      port45_o          <= TPFS_RST_BIT;
      port45_pullup_o   <= TPFS_RST_BIT;
      port44_pullup_o   <= TPFS_RST_BIT;
      ext_irq0_input_o  <= TPFS_RST_BIT;
      sub_osc_buf_en_o  <= TPFS_RST_BIT;
      sub_osc_fb_en_o   <= TPFS_RST_BIT;
      timer_b_role_o    <= TPFS_TB_IDLE;
      timer_b_out_oe_o  <= TPFS_RST_BIT;
      chan_a_role_o     <= TPFS_RST_FUNC;
      chan_b_role_o     <= TPFS_RST_FUNC;
      chan_c_role_o     <= TPFS_RST_FUNC;
      chan_d_role_o     <= TPFS_RST_FUNC;
      timer_c_trig_in_o <= TPFS_RST_BIT;
    end else begin
      port45_oe_o       <= p45_oe_next;
      port45_o          <= p45_out_next;
      port45_pullup_o   <= p45_pu_next;
      port44_pullup_o   <= p44_pu_next;
      ext_irq0_input_o  <= irq0_next;
      sub_osc_buf_en_o  <= buf_next;
      sub_osc_fb_en_o   <= fb_next;
      timer_b_role_o    <= tb_role_next;
      timer_b_out_oe_o  <= tb_oe_next;
      chan_a_role_o     <= role_a;
      chan_b_role_o     <= role_b;
      chan_c_role_o     <= role_c;
      chan_d_role_o     <= role_d;
      timer_c_trig_in_o <= trig_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks on the pin decode
  property p_dir;
    @(posedge clock_i) disable iff (rst_i)
      1'b1 |=> port45_oe_o == $past(port4_ctl_i.port45_direction);
  endproperty
  a_dir: assert property (p_dir) else $error("p4_5 drive does not follow direction");

  property p_irq;
    @(posedge clock_i) disable iff (rst_i)
      port4_ctl_i.port45_direction |=> !ext_irq0_input_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq0 fed while pin is output");

  property p_irq_off;
    @(posedge clock_i) disable iff (rst_i)
      !port4_ctl_i.ext_irq0_pin_enable |=> !ext_irq0_input_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq0 fed while pin disabled");

  property p_pulse;
    @(posedge clock_i) disable iff (rst_i)
      (!timer_b_output_ctl_i && !timer_b_op_sel_hi_i && timer_b_op_sel_lo_i)
        |=> timer_b_role_o == TPFS_TB_PULSE && timer_b_out_oe_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("timer b pulse role missing");

  property p_prog;
    @(posedge clock_i) disable iff (rst_i)
      (timer_b_output_ctl_i && !timer_b_op_sel_hi_i && timer_b_op_sel_lo_i)
        |=> timer_b_role_o == TPFS_TB_PROG;
  endproperty
  a_prog: assert property (p_prog) else $error("timer b programmable role missing");

  property p_shot;
    @(posedge clock_i) disable iff (rst_i)
      (!timer_b_output_ctl_i && timer_b_op_sel_hi_i && !timer_b_op_sel_lo_i)
        |=> timer_b_role_o == TPFS_TB_SHOT;
  endproperty
  a_shot: assert property (p_shot) else $error("timer b one-shot role missing");

  property p_wshot;
    @(posedge clock_i) disable iff (rst_i)
      (!timer_b_output_ctl_i && timer_b_op_sel_hi_i && timer_b_op_sel_lo_i)
        |=> timer_b_role_o == TPFS_TB_WSHOT;
  endproperty
  a_wshot: assert property (p_wshot) else $error("timer b wait one-shot role missing");

  property p_oc;
    @(posedge clock_i) disable iff (rst_i)
      (!chan_c_ctl_i.out_off && pwm_two_sel_i && !chan_c_ctl_i.pwm_sel &&
       chan_c_ctl_i.io_ctl == 3'h1) |=> chan_c_role_o == TPFS_CH_OC;
  endproperty
  a_oc: assert property (p_oc) else $error("channel c output compare missing");

  property p_ic;
    @(posedge clock_i) disable iff (rst_i)
      (pwm_two_sel_i && chan_a_ctl_i.io_ctl[2]) |=> chan_a_role_o == TPFS_CH_IC;
  endproperty
  a_ic: assert property (p_ic) else $error("channel a capture missing");

  property p_ic_b;
    @(posedge clock_i) disable iff (rst_i)
      (pwm_two_sel_i && !chan_b_ctl_i.pwm_sel && chan_b_ctl_i.io_ctl[TPFS_IO_TOP_BIT])
        |=> chan_b_role_o == TPFS_CH_IC;
  endproperty
  a_ic_b: assert property (p_ic_b) else $error("channel b capture missing");

  property p_pwm;
    @(posedge clock_i) disable iff (rst_i)
      (!chan_d_ctl_i.out_off && pwm_two_sel_i && chan_d_ctl_i.pwm_sel)
        |=> chan_d_role_o == TPFS_CH_PWM;
  endproperty
  a_pwm: assert property (p_pwm) else $error("channel d pwm missing");

  property p_pwm_two;
    @(posedge clock_i) disable iff (rst_i)
      (!chan_b_ctl_i.out_off && !pwm_two_sel_i && !chan_b_ctl_i.pwm_sel)
        |=> chan_b_role_o == TPFS_CH_PWM_TWO;
  endproperty
  a_pwm_two: assert property (p_pwm_two) else $error("channel b pwm-two missing");

  // channels c and d have no pin role at all in pwm-two mode
  property p_cd_quiet;
    @(posedge clock_i) disable iff (rst_i)
      !pwm_two_sel_i |=> chan_c_role_o == TPFS_CH_NONE && chan_d_role_o == TPFS_CH_NONE;
  endproperty
  a_cd_quiet: assert property (p_cd_quiet) else $error("c or d active in pwm-two");

  property p_trig;
    @(posedge clock_i) disable iff (rst_i)
      (chan_a_ctl_i.out_off && !pwm_two_sel_i && trig_edge != 2'h0)
        |=> chan_a_role_o == TPFS_CH_TRIG;
  endproperty
  a_trig: assert property (p_trig) else $error("channel a trigger missing");

  property p_stop;
    @(posedge clock_i) disable iff (rst_i)
      port4_ctl_i.all_clock_stop |=> !sub_osc_buf_en_o && !sub_osc_fb_en_o;
  endproperty
  a_stop: assert property (p_stop) else $error("sub-osc alive in stop mode");

  property p_pull;
    @(posedge clock_i) disable iff (rst_i)
      !port4_ctl_i.port4_group_pullup |=> !port45_pullup_o && !port44_pullup_o;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up on without group bit");

  c_pulse: cover property (@(posedge clock_i) timer_b_role_o == TPFS_TB_PULSE);
  c_trig:  cover property (@(posedge clock_i) timer_c_trig_in_o);
  c_irq:   cover property (@(posedge clock_i) ext_irq0_input_o);
  c_pwm_two: cover property (@(posedge clock_i) chan_b_role_o == TPFS_CH_PWM_TWO);
  c_oc:    cover property (@(posedge clock_i) chan_c_role_o == TPFS_CH_OC);

endmodule // tpfs_top

// File: verif/tpfs_pad_model.sv
// partner model of one shared pad: device drive, board drive, pull-up or floating
`timescale 1ns/10ps
module tpfs_pad_model (
  input  wire logic clock_i,  // system clock, paces the floating level
  input  wire logic oe_i,     // device drives the pad
  input  wire logic dout_i,   // device drive level
  input  wire logic pullup_i, // device pull-up on
  input  wire logic ext_en_i, // board drives the pad
  input  wire logic ext_i,    // board drive level
  output logic      pad_o     // resolved pad level
);
  logic float_reg = 1'b0;     // level of an open pad, changes every cycle

  ////////////////////////////////////////////////////////////////
  // an open pad wanders so a stale level never passes for a real one
  always @(posedge clock_i) begin
    float_reg <= ~float_reg;
  end

  // resolve who owns the pad
  always_comb begin
    if (oe_i) begin
      pad_o = dout_i;
    end else if (ext_en_i) begin
      pad_o = ext_i;          // board wins over the weak pull-up
    end else if (pullup_i) begin
      pad_o = 1'b1;
    end else begin
      pad_o = float_reg;
    end
  end
endmodule // tpfs_pad_model

// File: verif/tb_tpfs_top.sv
// self-checking testbench of the timer and port 4 pin function select
`timescale 1ns/10ps
module tb_tpfs_top
  import tpfs_pkg::*;
;
  logic clock_i, rst_i, tb_ctl, tb_hi, tb_lo, pwm_two, eh, el, p45_out;
  logic ext45_en, ext45, exta, pad45, pada;   // board side of the pads
  tpfs_port4_ctl_t p4;                        // port 4 control bits
  tpfs_chan_ctl_t  ca, cb, cc, cd;            // timer c channel controls
  logic oe45, o45, pu45, pu44, irq0, buf_en, fb_en, tb_oe, trig;
  tpfs_tb_role_t   tb_role;                   // timer b pin role
  logic [2:0]      ra, rb, rc, rd;            // timer c pin roles
  int fail_count, n_tests, i;
  localparam tpfs_tb_role_t TB_EXP [8] = '{TPFS_TB_IDLE, TPFS_TB_PULSE, TPFS_TB_SHOT,
    TPFS_TB_WSHOT, TPFS_TB_IDLE, TPFS_TB_PROG, TPFS_TB_IDLE, TPFS_TB_IDLE};

  ////////////////////////////////////////////////////////////////
  tpfs_top uut (.clock_i(clock_i), .rst_i(rst_i), .port4_ctl_i(p4),
    .timer_b_output_ctl_i(tb_ctl), .timer_b_op_sel_hi_i(tb_hi), .timer_b_op_sel_lo_i(tb_lo),
    .chan_a_ctl_i(ca), .chan_b_ctl_i(cb), .chan_c_ctl_i(cc), .chan_d_ctl_i(cd),
    .pwm_two_sel_i(pwm_two), .trig_edge_sel_hi_i(eh), .trig_edge_sel_lo_i(el),
    .port45_pad_i(pad45), .port45_out_i(p45_out), .timer_c_pin_a_pad_i(pada),
    .port45_oe_o(oe45), .port45_o(o45), .port45_pullup_o(pu45), .port44_pullup_o(pu44),
    .ext_irq0_input_o(irq0), .sub_osc_buf_en_o(buf_en), .sub_osc_fb_en_o(fb_en),
    .timer_b_role_o(tb_role), .timer_b_out_oe_o(tb_oe), .chan_a_role_o(ra),
    .chan_b_role_o(rb), .chan_c_role_o(rc), .chan_d_role_o(rd), .timer_c_trig_in_o(trig));
  tpfs_pad_model pm45 (.clock_i(clock_i), .oe_i(oe45), .dout_i(o45), .pullup_i(pu45),
    .ext_en_i(ext45_en), .ext_i(ext45), .pad_o(pad45));
  tpfs_pad_model pma (.clock_i(clock_i), .oe_i(1'b0), .dout_i(1'b0), .pullup_i(1'b0),
    .ext_en_i(1'b1), .ext_i(exta), .pad_o(pada));

  ////////////////////////////////////////////////////////////////
  // compare one value, count it, report a mismatch at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // print counts and verdict, end the run
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // expected role of timer c channel k for the given controls
  function automatic logic [2:0] exp_ch(int k, tpfs_chan_ctl_t c, logic p2, logic [1:0] e);
    if (k == 0 && !p2) return (c.out_off && e != 2'h0) ? TPFS_CH_TRIG : TPFS_CH_NONE;
    if (k != 0 && p2 && c.pwm_sel) return c.out_off ? TPFS_CH_NONE : TPFS_CH_PWM;
    if (p2 && c.io_ctl[2]) return TPFS_CH_IC;
    if (p2 && !c.out_off && c.io_ctl[1:0] != 2'h0) return TPFS_CH_OC;
    if (k == 1 && !p2 && !c.out_off && !c.pwm_sel) return TPFS_CH_PWM_TWO;
    return TPFS_CH_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // cut a hang short
  initial begin
    #80000;
    fail_count++;
    $display("CHECK FAILED at %0t: run too long", $time);
    close_out;
  end

  // main sequence, inputs change on the falling edge
  initial begin
    fail_count = 0; n_tests = 0; rst_i = 1'b1;
    p4 = '0; ca = '0; cb = '0; cc = '0; cd = '0;
    {tb_ctl, tb_hi, tb_lo, pwm_two, eh, el, p45_out, ext45_en, ext45, exta} = '0;
    repeat (3) @(negedge clock_i);
    chk(8'(tb_role), 8'(TPFS_TB_IDLE), "reset role");
    chk(8'({oe45, irq0, tb_oe, trig, ra}), 8'h0, "reset outputs");
    repeat (3) @(negedge clock_i);
    rst_i = 1'b0;
    // timer b pin role over every control and mode value
    for (i = 0; i < 8; i++) begin
      {tb_ctl, tb_hi, tb_lo} = i[2:0];
      @(negedge clock_i);
      chk(8'(tb_role), 8'(TB_EXP[i]), "timer b role");
      chk(8'(tb_oe), 8'(TB_EXP[i] != TPFS_TB_IDLE), "timer b oe");
    end
    // timer c channel roles over every control combination
    for (i = 0; i < 256; i++) begin
      ca = i[4:0]; cb = i[4:0]; cc = i[4:0]; cd = i[4:0];
      pwm_two = i[5]; {eh, el} = i[7:6];
      @(negedge clock_i);
      chk(8'(ra), 8'(exp_ch(0, ca, pwm_two, {eh, el})), "chan a");
      chk(8'(rb), 8'(exp_ch(1, cb, pwm_two, {eh, el})), "chan b");
      chk(8'(rc), 8'(exp_ch(2, cc, pwm_two, {eh, el})), "chan c");
      chk(8'(rd), 8'(exp_ch(3, cd, pwm_two, {eh, el})), "chan d");
    end
    // port 4 direction, pull-ups and sub-clock controls
    for (i = 0; i < 64; i++) begin
      p4 = i[5:0]; p45_out = ~i[1];
      @(negedge clock_i);
      chk(8'(oe45), 8'(p4.port45_direction), "p45 oe");
      if (oe45 === 1'b1) chk(8'(o45), 8'(p45_out), "p45 level");
      chk(8'(pu45), 8'(p4.port4_group_pullup & ~p4.port45_direction), "p45 pu");
      chk(8'(pu44), 8'(p4.port4_group_pullup & ~p4.sub_osc_buf_req), "p44 pu");
      chk(8'(buf_en), 8'(p4.sub_osc_buf_req & ~p4.all_clock_stop), "osc buf");
      chk(8'(fb_en), 8'(p4.sub_osc_fb_req & ~p4.all_clock_stop), "osc fb");
    end
    // interrupt pin path, board drives the pad and the group pull-up bit stays clear
    p4 = '0; p4.ext_irq0_pin_enable = 1'b1; p4.sub_osc_buf_req = 1'b1;
    ext45_en = 1'b1;
    for (i = 0; i < 4; i++) begin
      ext45 = i[0]; p4.ext_irq0_pin_enable = ~i[1];
      repeat (4) @(negedge clock_i);
      chk(8'(irq0), 8'(i[0] & ~i[1]), "irq0 follows pad");
    end
    // released pad held high by the pull-up feeds the interrupt
    p4 = '0; p4.ext_irq0_pin_enable = 1'b1; p4.port4_group_pullup = 1'b1; ext45_en = 1'b0;
    repeat (4) @(negedge clock_i);
    chk(8'({pad45, irq0}), 8'h3, "pulled-up pad");
    p4.port45_direction = 1'b1; p45_out = 1'b0;
    repeat (4) @(negedge clock_i);
    chk(8'({pad45, irq0, pu45}), 8'h0, "output blocks irq0");
    // trigger input on timer c pin a
    ca = '0; ca.out_off = 1'b1; pwm_two = 1'b0;
    for (i = 0; i < 8; i++) begin
      {eh, el} = i[1:0]; exta = ~i[2];
      repeat (4) @(negedge clock_i);
      chk(8'(trig), 8'(~i[2] & (i[1:0] != 2'h0)), "trigger level");
    end
    // reset again in mid-run
    tb_ctl = 1'b1; tb_hi = 1'b0; tb_lo = 1'b1; rst_i = 1'b1;
    @(negedge clock_i);
    chk(8'({tb_role, oe45}), 8'({TPFS_TB_IDLE, 1'b0}), "mid-run reset");
    rst_i = 1'b0;
    @(negedge clock_i);
    chk(8'({tb_role, oe45}), 8'({TPFS_TB_PROG, 1'b1}), "after reset");
    close_out;
  end
endmodule // tb_tpfs_top
